// ===== rtl/motion_cfg_pkg.sv
// constants and lookups for the motion detector configuration block
`default_nettype none
package motion_cfg_pkg;

	// ------------------------------------------------------------
	// mode strap levels
	// ------------------------------------------------------------
	localparam logic [1:0] LVL_GND = 2'h0;
	localparam logic [1:0] LVL_OPEN = 2'h1;
	localparam logic [1:0] LVL_PULLUP = 2'h2;
	localparam logic [1:0] LVL_VDD = 2'h3;

	// ------------------------------------------------------------
	// register indices, fields and reset values
	// ------------------------------------------------------------
	localparam logic [6:0] STATUS_IDX = 7'h00;
	localparam logic [6:0] DETECT_LEVEL_IDX = 7'h02;
	localparam logic [6:0] LINGER_TIME_IDX = 7'h0A;
	localparam int THR_W = 13;
	localparam int HOLD_W = 16;
	localparam logic [12:0] THR_RESET = 13'h0050;
	localparam logic [15:0] HOLD_RESET = 16'h03E8;
	localparam int FRAME_BITS = 24;
	localparam int HDR_BITS = 8;
	localparam logic [3:0] BASIC_LOW_BITS = 4'h2;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int MS_TIME = 1;
	localparam int MS_CYCLES = CLK_HZ / 1000 * MS_TIME;
	localparam int MEAN_WINDOW_US = 500;
	localparam int MEAN_WINDOW_CYCLES = CLK_HZ / 1_000_000 * MEAN_WINDOW_US;
	localparam int HOLD_CNT_W = 21;

	typedef enum logic [1:0] {
		ST_BOOT = 2'b00,
		ST_RUN = 2'b01
	} cfg_state_t;

	// threshold level code to detector threshold
	function automatic logic [12:0] thr_lookup(input logic [3:0] code);
		case (code)
			4'h0: thr_lookup = 13'd61;
			4'h1: thr_lookup = 13'd66;
			4'h2: thr_lookup = 13'd80;
			4'h3: thr_lookup = 13'd90;
			4'h4: thr_lookup = 13'd112;
			4'h5: thr_lookup = 13'd136;
			4'h6: thr_lookup = 13'd192;
			4'h7: thr_lookup = 13'd248;
			4'h8: thr_lookup = 13'd320;
			4'h9: thr_lookup = 13'd284;
			4'hA: thr_lookup = 13'd480;
			4'hB: thr_lookup = 13'd640;
			4'hC: thr_lookup = 13'd896;
			4'hD: thr_lookup = 13'd1344;
			4'hE: thr_lookup = 13'd1920;
			default: thr_lookup = 13'd2560;
		endcase
	endfunction

	// hold level code to hold time in ms; code 0 depends on PRT
	function automatic logic [20:0] hold_lookup(input logic [3:0] code,
			input logic [1:0] prt);
		case (code)
			4'h0: hold_lookup = (prt == 2'h2) ? 21'd16 :
				(prt == 2'h0) ? 21'd32 :
				(prt == 2'h3) ? 21'd64 : 21'd128;
			4'h1: hold_lookup = 21'd500;
			4'h2: hold_lookup = 21'd1000;
			4'h3: hold_lookup = 21'd2000;
			4'h4: hold_lookup = 21'd3000;
			4'h5: hold_lookup = 21'd5000;
			4'h6: hold_lookup = 21'd10000;
			4'h7: hold_lookup = 21'd30000;
			4'h8: hold_lookup = 21'd45000;
			4'h9: hold_lookup = 21'd60000;
			4'hA: hold_lookup = 21'd90000;
			4'hB: hold_lookup = 21'd120000;
			4'hC: hold_lookup = 21'd300000;
			4'hD: hold_lookup = 21'd600000;
			4'hE: hold_lookup = 21'd900000;
			default: hold_lookup = 21'd1800000;
		endcase
	endfunction

endpackage
`default_nettype wire

// ===== rtl/motion_detector_config.sv
// strap decode, spi registers and detector hold logic
`default_nettype none

module motion_detector_config #(
	parameter int MS_CYCLES = motion_cfg_pkg::MS_CYCLES,
	parameter int MEAN_WINDOW_CYCLES = motion_cfg_pkg::MEAN_WINDOW_CYCLES
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [1:0] mode_strap,
	input wire logic boot_option,
	input wire logic [1:0] prt_strap,
	input wire logic [3:0] threshold_strap,
	input wire logic [3:0] linger_strap,
	input wire logic [12:0] strength,
	input wire logic strength_valid,
	input wire logic approaching,
	input wire logic spi_csn,
	input wire logic spi_sck,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	output logic presence_flag_n,
	output logic approach_flag,
	output logic spi_mode,
	output logic ext_clk_en,
	output logic advance_mode
);

	// ------------------------------------------------------------
	// parameter checks
	// ------------------------------------------------------------
	if (MS_CYCLES < 1 || MS_CYCLES > 1048576) begin : g_chk_ms
		$error("MS_CYCLES out of range");
	end
	if (MEAN_WINDOW_CYCLES < 1 || MEAN_WINDOW_CYCLES > 1048576) begin : g_chk_w
		$error("MEAN_WINDOW_CYCLES out of range");
	end

	// ------------------------------------------------------------
	// boot capture
	// ------------------------------------------------------------
	motion_cfg_pkg::cfg_state_t state_q;
	logic [1:0] mode_q;
	logic [1:0] prt_q;
	logic adv_q;
	logic auto_mode;

	assign auto_mode = (mode_q == motion_cfg_pkg::LVL_GND) ||
		(mode_q == motion_cfg_pkg::LVL_OPEN);

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_q <= motion_cfg_pkg::ST_BOOT;
			mode_q <= motion_cfg_pkg::LVL_VDD;
			prt_q <= 2'h0;
			adv_q <= 1'b0;
		end else begin
			case (state_q)
				motion_cfg_pkg::ST_BOOT: begin
					mode_q <= mode_strap;
					prt_q <= prt_strap;
					adv_q <= boot_option && !mode_strap[1];
					state_q <= motion_cfg_pkg::ST_RUN;
				end
				default: state_q <= motion_cfg_pkg::ST_RUN;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			spi_mode <= 1'b1;
			ext_clk_en <= 1'b0;
			advance_mode <= 1'b0;
		end else begin
			spi_mode <= !auto_mode;
			ext_clk_en <= (mode_q == motion_cfg_pkg::LVL_PULLUP);
			advance_mode <= adv_q;
		end
	end

	// ------------------------------------------------------------
	// mean window and strap level sampling
	// ------------------------------------------------------------
	logic [19:0] win_cnt_q;
	logic win_tick;
	logic [3:0] thr_code_q;
	logic [3:0] hold_code_q;

	assign win_tick = (win_cnt_q == 20'(MEAN_WINDOW_CYCLES - 1));

	always_ff @(posedge mclk) begin
		if (!nrst || win_tick) begin
			win_cnt_q <= 20'h00000;
		end else begin
			win_cnt_q <= win_cnt_q + 20'h00001;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			thr_code_q <= motion_cfg_pkg::BASIC_LOW_BITS;
			hold_code_q <= motion_cfg_pkg::BASIC_LOW_BITS;
		end else if (state_q == motion_cfg_pkg::ST_BOOT ||
				(win_tick && adv_q)) begin
			if (adv_q || (state_q == motion_cfg_pkg::ST_BOOT &&
					boot_option && !mode_strap[1])) begin
				thr_code_q <= threshold_strap;
				hold_code_q <= linger_strap;
			end else begin
				thr_code_q <= {threshold_strap[3:2],
					motion_cfg_pkg::BASIC_LOW_BITS[1:0]};
				hold_code_q <= {linger_strap[3:2],
					motion_cfg_pkg::BASIC_LOW_BITS[1:0]};
			end
		end
	end

	// ------------------------------------------------------------
	// spi register port
	// ------------------------------------------------------------
	logic [12:0] detect_level_q;
	logic [15:0] linger_time_q;
	logic sck_q;
	logic [4:0] bit_cnt_q;
	logic [23:0] shift_q;
	logic [15:0] tx_q;
	logic active_q;
	logic sck_rise;
	logic sck_fall;
	logic [23:0] frame;

	assign sck_rise = spi_sck && !sck_q && !spi_csn;
	assign sck_fall = !spi_sck && sck_q && !spi_csn;
	// bits so far plus mosi now; index lands in the top seven
	assign frame = {shift_q[22:0], spi_mosi};

	function automatic logic [15:0] reg_read(input logic [6:0] idx,
			input logic [12:0] thr, input logic [15:0] hold,
			input logic [3:0] st);
		if (idx == motion_cfg_pkg::DETECT_LEVEL_IDX) begin
			reg_read = {3'h0, thr};
		end else if (idx == motion_cfg_pkg::LINGER_TIME_IDX) begin
			reg_read = hold;
		end else if (idx == motion_cfg_pkg::STATUS_IDX) begin
			reg_read = {12'h000, st};
		end else begin
			reg_read = 16'h0000;
		end
	endfunction

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sck_q <= 1'b0;
		end else begin
			sck_q <= spi_sck;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst || spi_csn) begin
			bit_cnt_q <= 5'h00;
			shift_q <= 24'h000000;
		end else if (sck_rise) begin
			shift_q <= frame;
			bit_cnt_q <= bit_cnt_q + 5'h01;
		end
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			detect_level_q <= motion_cfg_pkg::THR_RESET;
			linger_time_q <= motion_cfg_pkg::HOLD_RESET;
		end else if (sck_rise && !auto_mode &&
				bit_cnt_q == 5'(motion_cfg_pkg::FRAME_BITS - 1) &&
				frame[16]) begin
			if (frame[23:17] == motion_cfg_pkg::DETECT_LEVEL_IDX) begin
				detect_level_q <= frame[12:0];
			end else if (frame[23:17] ==
					motion_cfg_pkg::LINGER_TIME_IDX) begin
				linger_time_q <= frame[15:0];
			end
		end
	end

	// ------------------------------------------------------------
	// read data shifter
	// ------------------------------------------------------------

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			tx_q <= 16'h0000;
			spi_miso <= 1'b0;
			spi_miso_oe <= 1'b0;
		end else begin
			spi_miso_oe <= !spi_csn;
			if (sck_rise && bit_cnt_q == 5'(motion_cfg_pkg::HDR_BITS - 1)) begin
				tx_q <= reg_read(frame[7:1], detect_level_q,
					linger_time_q, {adv_q, active_q, mode_q});
			end else if (sck_fall &&
					bit_cnt_q >= 5'(motion_cfg_pkg::HDR_BITS)) begin
				spi_miso <= tx_q[15];
				tx_q <= {tx_q[14:0], 1'b0};
			end
		end
	end

	// ------------------------------------------------------------
	// detector and hold countdown
	// ------------------------------------------------------------
	logic [12:0] thr_sel;
	logic [20:0] hold_sel;
	logic [19:0] ms_cnt_q;
	logic ms_tick;
	logic [20:0] hold_q;
	logic hit;

	always_comb begin
		if (auto_mode) begin
			thr_sel = motion_cfg_pkg::thr_lookup(thr_code_q);
			hold_sel = motion_cfg_pkg::hold_lookup(hold_code_q,
				prt_q);
		end else begin
			thr_sel = detect_level_q;
			hold_sel = {5'h00, linger_time_q};
		end
	end

	assign hit = strength_valid && (strength >= thr_sel) &&
		state_q == motion_cfg_pkg::ST_RUN;
	assign ms_tick = (ms_cnt_q == 20'(MS_CYCLES - 1));

	always_ff @(posedge mclk) begin
		if (!nrst || hit || ms_tick) begin
			ms_cnt_q <= 20'h00000;
		end else begin
			ms_cnt_q <= ms_cnt_q + 20'h00001;
		end
	end

	// ------------------------------------------------------------
	// hold countdown
	// ------------------------------------------------------------

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			hold_q <= 21'h000000;
			active_q <= 1'b0;
		// a hit in the expiry cycle wins
		end else if (hit) begin
			hold_q <= hold_sel;
			active_q <= 1'b1;
		end else if (active_q && ms_tick) begin
			if (hold_q <= 21'h000001) begin
				hold_q <= 21'h000000;
				active_q <= 1'b0;
			end else begin
				hold_q <= hold_q - 21'h000001;
			end
		end
	end

	// ------------------------------------------------------------
	// detector outputs
	// ------------------------------------------------------------

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			presence_flag_n <= 1'b1;
			approach_flag <= 1'b0;
		end else begin
			presence_flag_n <= !(active_q || hit);
			if (hit) begin
				approach_flag <= approaching;
			end else if (!active_q) begin
				approach_flag <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// ===== verification/spi_host_model.sv
// host model that sends register frames to the block
`default_nettype none
module spi_host_model (
	input wire logic mclk,
	input wire logic miso,
	output logic csn,
	output logic sck,
	output logic mosi
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		csn = 1'b1;
		sck = 1'b0;
		mosi = 1'b0;
	end
	// index, write bit, 16 data bits, msb first
	task automatic xfer(input logic [23:0] f, output logic [15:0] rd);
		@(negedge mclk);
		csn = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			mosi = f[i];
			repeat (3) @(negedge mclk);
			if (i < 16)
				rd[i] = miso;
			sck = 1'b1;
			repeat (3) @(negedge mclk);
			sck = 1'b0;
		end
		repeat (3) @(negedge mclk);
		csn = 1'b1;
		// released line must not keep its last bit
		mosi = ~mosi;
	endtask
endmodule
`default_nettype wire

// ===== verification/motion_cfg_chk.sv
// port assertions for the motion detector configuration block
`default_nettype none
module motion_cfg_chk (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [1:0] mode_strap,
	input wire logic boot_option,
	input wire logic strength_valid,
	input wire logic approaching,
	input wire logic spi_csn,
	input wire logic spi_miso_oe,
	input wire logic presence_flag_n,
	input wire logic approach_flag,
	input wire logic spi_mode,
	input wire logic ext_clk_en,
	input wire logic advance_mode
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	logic rst_q;
	logic boot_edge;
	always_ff @(posedge mclk) begin
		rst_q <= nrst;
	end
	// high on the edge that captures the straps
	assign boot_edge = nrst && !rst_q;
	a_spi_mode_boot: assert property (
		$past(boot_edge, 2) |-> spi_mode == $past(mode_strap[1], 2))
		else $error("spi mode");
	a_ext_clk_boot: assert property (
		$past(boot_edge, 2) |->
		ext_clk_en == ($past(mode_strap, 2) == 2'h2))
		else $error("ext clock");
	a_advance_boot: assert property (
		$past(boot_edge, 2) |->
		advance_mode == ($past(boot_option, 2) && !$past(mode_strap[1], 2)))
		else $error("advance mode");
	a_mode_steady: assert property (
		rst_q && $past(rst_q) && $past(rst_q, 2) |->
		$stable(spi_mode) && $stable(advance_mode))
		else $error("mode moved");
	a_miso_enable: assert property (
		spi_miso_oe == !$past(spi_csn))
		else $error("miso enable");
	a_hit_cause: assert property (
		$fell(presence_flag_n) |-> $past(strength_valid))
		else $error("hit without strength");
	a_approach_follow: assert property (
		$fell(presence_flag_n) |-> approach_flag == $past(approaching))
		else $error("approach wrong");
	a_approach_idle: assert property (
		presence_flag_n |-> !approach_flag)
		else $error("approach idle");
	a_hold_floor: assert property (
		$fell(presence_flag_n) |-> !presence_flag_n [*8])
		else $error("hold short");
	cover property ($fell(presence_flag_n));
	cover property ($rose(advance_mode));
	cover property ($rose(ext_clk_en));
endmodule
bind motion_detector_config motion_cfg_chk chk_i (
	.mclk(mclk), .nrst(nrst), .mode_strap(mode_strap),
	.boot_option(boot_option), .strength_valid(strength_valid),
	.approaching(approaching), .spi_csn(spi_csn),
	.spi_miso_oe(spi_miso_oe), .presence_flag_n(presence_flag_n),
	.approach_flag(approach_flag), .spi_mode(spi_mode),
	.ext_clk_en(ext_clk_en), .advance_mode(advance_mode)
);
`default_nettype wire

// ===== verification/motion_detector_config_bench.sv
// self-checking bench for the motion detector configuration block
`default_nettype none
module motion_detector_config_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [1:0] mode = 2'h3;
	logic bopt = 1'b0;
	logic [1:0] prt = 2'h0;
	logic [3:0] thr_s = 4'h1;
	logic [3:0] lin_s = 4'h1;
	logic [12:0] strength = 13'h0000;
	logic valid = 1'b0;
	logic appr_in = 1'b0;
	logic csn, sck, mosi, miso, pres_n, appr, spi_md, ext_en, adv;
	logic [15:0] rd;
	int fails = 0;
	int n_checks = 0;
	int thr[16] = '{61, 66, 80, 90, 112, 136, 192, 248, 320, 284, 480, 640,
		896, 1344, 1920, 2560};
	int min_ms[4] = '{32, 128, 16, 64};
	int lin_ms[3] = '{500, 1000, 2000};
	always #5 mclk = ~mclk;
	motion_detector_config #(.MS_CYCLES(10), .MEAN_WINDOW_CYCLES(8)) uut (
		.mclk(mclk), .nrst(nrst), .mode_strap(mode), .boot_option(bopt),
		.prt_strap(prt), .threshold_strap(thr_s), .linger_strap(lin_s),
		.strength(strength), .strength_valid(valid), .approaching(appr_in),
		.spi_csn(csn), .spi_sck(sck), .spi_mosi(mosi), .spi_miso(miso),
		.spi_miso_oe(), .presence_flag_n(pres_n), .approach_flag(appr),
		.spi_mode(spi_md), .ext_clk_en(ext_en), .advance_mode(adv)
	);
	spi_host_model host (
		.mclk(mclk), .miso(miso), .csn(csn), .sck(sck), .mosi(mosi)
	);
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic boot(input logic [1:0] m, input logic b, input logic [1:0] p);
		nrst = 1'b0;
		mode = m;
		bopt = b;
		prt = p;
		repeat (16) @(negedge mclk);
		nrst = 1'b1;
		repeat (4) @(negedge mclk);
	endtask
	task automatic hit(input int s, input logic a);
		strength = s[12:0];
		appr_in = a;
		valid = 1'b1;
		@(negedge mclk);
		valid = 1'b0;
		@(negedge mclk);
	endtask
	// counts cycles the presence flag stays low, bounded
	task automatic hold_len(input int exp);
		int c;
		c = 0;
		while (pres_n === 1'b0 && c < 40000) begin
			c++;
			@(negedge mclk);
		end
		if (c >= 40000) begin
			fails++;
			$display("Error %0t: presence never released", $time);
			test_done();
		end else begin
			chk(c[15:0], exp[15:0]);
		end
	endtask
	task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
		host.xfer({a, 1'b0, 16'h0000}, rd);
		chk(rd, exp);
	endtask
	initial begin
		@(negedge mclk);
		boot(motion_cfg_pkg::LVL_VDD, 1'b0, 2'h0);
		chk(spi_md, 1'b1);
		rdc(motion_cfg_pkg::DETECT_LEVEL_IDX, 16'h0050);
		rdc(motion_cfg_pkg::LINGER_TIME_IDX, 16'h03E8);
		rdc(7'h05, 16'h0000);
		host.xfer({motion_cfg_pkg::DETECT_LEVEL_IDX, 17'h100C8}, rd);
		host.xfer({motion_cfg_pkg::LINGER_TIME_IDX, 17'h10003}, rd);
		rdc(motion_cfg_pkg::DETECT_LEVEL_IDX, 16'h00C8);
		hit(199, 1'b1);
		chk(pres_n, 1'b1);
		hit(200, 1'b1);
		chk(appr, 1'b1);
		repeat (20) @(negedge mclk);
		hit(200, 1'b0);
		hold_len(30);
		boot(motion_cfg_pkg::LVL_PULLUP, 1'b0, 2'h0);
		chk(ext_en, 1'b1);
		boot(motion_cfg_pkg::LVL_GND, 1'b0, 2'h0);
		chk(spi_md, 1'b0);
		host.xfer({motion_cfg_pkg::DETECT_LEVEL_IDX, 17'h11FFF}, rd);
		rdc(motion_cfg_pkg::DETECT_LEVEL_IDX, 16'h0050);
		hit(79, 1'b0);
		chk(pres_n, 1'b1);
		hit(80, 1'b0);
		hold_len(10000);
		thr_s = 4'hF;
		lin_s = 4'h0;
		for (int p = 0; p < 4; p++) begin
			boot(motion_cfg_pkg::LVL_OPEN, 1'b1, p[1:0]);
			chk(adv, 1'b1);
			hit(2560, 1'b0);
			hold_len(min_ms[p] * 10);
		end
		for (int k = 0; k < 16; k++) begin
			thr_s = k[3:0];
			repeat (20) @(negedge mclk);
			hit(thr[k] - 1, 1'b1);
			chk(pres_n, 1'b1);
			hit(thr[k], 1'b1);
			chk(pres_n, 1'b0);
			hold_len(640);
		end
		for (int k = 1; k < 4; k++) begin
			lin_s = k[3:0];
			repeat (20) @(negedge mclk);
			hit(8191, 1'b0);
			hold_len(lin_ms[k - 1] * 10);
		end
		test_done();
	end
endmodule
`default_nettype wire
